// ---- id_rom_regs_pkg.sv ----
// package: register map, fields, reset values and states of the register bank
//------------------------------------------------------------------------------
// Overview of operation
// - bit 31 write-one clears address; self-clears
// - address clear leaves read byte untouched
// - bit 25 starts byte read; self-clears
// - read byte lands in bits 23..16
// - pointer field reads 00h without eeprom
// - pointer loaded from eeprom offset 28h
// - present flag set on detect, reset-only clear
// - reserved bits read as zero
// - dual-phase limit fields read as zero
// - physical response retries, bits 11..8, reset 0
// - async response retries, bits 7..4, reset 0
// - async request retries, bits 3..0, reset 0
//------------------------------------------------------------------------------
package id_rom_regs_pkg;
    // register byte offsets
    localparam logic [7:0]  VERSION_OFS       = 8'h00;
    localparam logic [7:0]  ACCESS_OFS        = 8'h04;
    localparam logic [7:0]  RETRY_OFS         = 8'h08;
    // version register contents
    localparam int          PRESENT_BIT       = 24;
    localparam logic [7:0]  VERSION_MAJOR     = 8'h01;
    localparam logic [7:0]  VERSION_MINOR     = 8'h10;
    // access register fields
    localparam int          ADDR_CLEAR_BIT    = 31;
    localparam int          READ_GO_BIT       = 25;
    localparam int          READ_BYTE_LSB     = 16;
    localparam int          POINTER_LSB       = 0;
    // eeprom word holding the small rom pointer
    localparam logic [7:0]  POINTER_ROM_OFS   = 8'h28;
    localparam logic [7:0]  POINTER_RESET     = 8'h00;
    localparam logic [7:0]  READ_BYTE_RESET   = 8'h00;
    // retry register fields; unit index equals field number
    localparam int          RETRY_UNITS       = 3;
    localparam int          RETRY_W           = 4;
    localparam int          REQ_UNIT          = 0;  // bits 3..0
    localparam int          RESP_UNIT         = 1;  // bits 7..4
    localparam int          PHYS_UNIT         = 2;  // bits 11..8
    localparam logic [11:0] RETRY_RESET       = 12'h000;
    // axi response codes
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;
    // byte reader states
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT_BYTE,
        RD_WAIT_PTR
    } reader_state_t;
endpackage : id_rom_regs_pkg

// ---- rom_rd_if.sv ----
// interface: requests and completions between bank and byte reader
`timescale 1ns/1ps
`default_nettype none
interface rom_rd_if;
    logic       read_go;     // level: a byte read is requested
    logic       addr_clear;  // level: an address clear is requested
    logic       read_done;   // pulse: byte read finished
    logic       clear_done;  // pulse: address clear finished
    logic [7:0] read_byte;   // last byte fetched by a read
    logic [7:0] pointer;     // small rom pointer
    modport bank (output read_go, addr_clear,
                  input  read_done, clear_done, read_byte, pointer);
    modport reader (input  read_go, addr_clear,
                    output read_done, clear_done, read_byte, pointer);
endinterface : rom_rd_if
`default_nettype wire

// ---- rom_byte_reader.sv ----
// module: byte-wise eeprom reader with address counter and pointer fetch
`timescale 1ns/1ps
`default_nettype none
module rom_byte_reader
    import id_rom_regs_pkg::*;
(
    input  wire logic   sys_clk_i,
    input  wire logic   rst_i,
    rom_rd_if.reader    rd,
    input  wire logic   present_i,   // eeprom detected (sticky)
    output logic        rom_req_o,   // byte request to sequencer
    output logic [7:0]  rom_addr_o,  // byte address of request
    input  wire logic   rom_ack_i,   // byte returned
    input  wire logic [7:0] rom_data_i
);
    reader_state_t state_r, state_nxt;
    logic [7:0] addr_r, addr_nxt;       // current byte address
    logic [7:0] byte_r, byte_nxt;       // last read byte
    logic [7:0] ptr_r, ptr_nxt;         // small rom pointer
    logic       loaded_r, loaded_nxt;   // pointer fetched once
    logic       req_r, req_nxt;
    logic [7:0] raddr_r, raddr_nxt;
    logic       rdone_r, rdone_nxt;
    logic       cdone_r, cdone_nxt;

    // next state: pointer fetch first, then clears, then reads
    always_comb begin
        state_nxt  = state_r;
        addr_nxt   = addr_r;
        byte_nxt   = byte_r;
        ptr_nxt    = ptr_r;
        loaded_nxt = loaded_r;
        req_nxt    = 1'b0;
        raddr_nxt  = raddr_r;
        rdone_nxt  = 1'b0;
        cdone_nxt  = 1'b0;
        case (state_r)
            RD_IDLE: begin
                if (present_i && !loaded_r) begin
                    req_nxt   = 1'b1;
                    raddr_nxt = POINTER_ROM_OFS;
                    state_nxt = RD_WAIT_PTR;
                end else if (rd.addr_clear && !cdone_r) begin
                    addr_nxt  = 8'h00;
                    cdone_nxt = 1'b1;              // byte kept
                end else if (rd.read_go && !rdone_r) begin
                    req_nxt   = 1'b1;
                    raddr_nxt = addr_r;
                    state_nxt = RD_WAIT_BYTE;
                end
            end
            RD_WAIT_BYTE: begin
                req_nxt = !rom_ack_i;
                if (rom_ack_i) begin
                    byte_nxt  = rom_data_i;
                    addr_nxt  = addr_r + 8'h01;
                    rdone_nxt = 1'b1;
                    state_nxt = RD_IDLE;
                end
            end
            RD_WAIT_PTR: begin
                req_nxt = !rom_ack_i;
                if (rom_ack_i) begin
                    ptr_nxt    = rom_data_i;
                    loaded_nxt = 1'b1;
                    state_nxt  = RD_IDLE;
                end
            end
            default: state_nxt = RD_IDLE;
        endcase
    end

    // registers; pointer resets to 00h
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r  <= RD_IDLE;
            addr_r   <= 8'h00;
            byte_r   <= READ_BYTE_RESET;
            ptr_r    <= POINTER_RESET;
            loaded_r <= 1'b0;
            req_r    <= 1'b0;
            raddr_r  <= 8'h00;
            rdone_r  <= 1'b0;
            cdone_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            addr_r   <= addr_nxt;
            byte_r   <= byte_nxt;
            ptr_r    <= ptr_nxt;
            loaded_r <= loaded_nxt;
            req_r    <= req_nxt;
            raddr_r  <= raddr_nxt;
            rdone_r  <= rdone_nxt;
            cdone_r  <= cdone_nxt;
        end
    end

    assign rom_req_o     = req_r;
    assign rom_addr_o    = raddr_r;
    assign rd.read_done  = rdone_r;
    assign rd.clear_done = cdone_r;
    assign rd.read_byte  = byte_r;
    assign rd.pointer    = ptr_r;
endmodule : rom_byte_reader
`default_nettype wire

// ---- retry_limiter.sv ----
// module: one transmit unit's retry counter against its programmed limit
`timescale 1ns/1ps
`default_nettype none
module retry_limiter #(
    parameter int CNT_W = 4
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [CNT_W-1:0] limit_i,      // allowed retransmissions
    input  wire logic             tx_done_i,    // pulse: attempt acked
    input  wire logic             ack_retry_i,  // busy or data error ack
    output logic                  resend_o,     // pulse: send again
    output logic                  give_up_o     // pulse: report failure
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic             rs_nxt, gu_nxt;

    // a zero limit gives up on the first bad ack
    always_comb begin
        cnt_nxt = cnt_r;
        rs_nxt  = 1'b0;
        gu_nxt  = 1'b0;
        if (tx_done_i) begin
            if (ack_retry_i && (cnt_r < limit_i)) begin
                cnt_nxt = cnt_r + 1'b1;
                rs_nxt  = 1'b1;
            end else begin
                cnt_nxt = '0;                // success or limit reached
                gu_nxt  = ack_retry_i;
            end
        end
    end

    // counter and pulse registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_r     <= '0;
            resend_o  <= 1'b0;
            give_up_o <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            resend_o  <= rs_nxt;
            give_up_o <= gu_nxt;
        end
    end
endmodule : retry_limiter
`default_nettype wire

// ---- id_rom_access_and_retry_regs.sv ----
// module: axi4-lite register bank for eeprom byte access and transmit retry limits
`timescale 1ns/1ps
`default_nettype none
module id_rom_access_and_retry_regs
    import id_rom_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    //--------------------------------------------------------------------------
    // axi4-lite slave
    //--------------------------------------------------------------------------
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    //--------------------------------------------------------------------------
    // eeprom byte sequencer
    //--------------------------------------------------------------------------
    input  wire logic              eeprom_detect_i,  // level: eeprom seen
    output logic                   rom_req_o,
    output logic [7:0]             rom_addr_o,
    input  wire logic              rom_ack_i,
    input  wire logic [7:0]        rom_data_i,
    //--------------------------------------------------------------------------
    // retry units: index 0 request, 1 response, 2 physical response
    //--------------------------------------------------------------------------
    input  wire logic [2:0]        tx_done_i,
    input  wire logic [2:0]        ack_retry_i,
    output logic [2:0]             resend_o,
    output logic [2:0]             give_up_o
);
    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    rom_rd_if rd ();                           // link to byte reader

    logic        present_r, present_nxt;       // eeprom present flag
    logic        go_r, go_nxt;                 // read-start bit
    logic        clr_r, clr_nxt;               // address-clear bit
    logic [11:0] retry_r, retry_nxt;           // three 4-bit limits

    logic              aw_held_r, aw_held_nxt; // write address captured
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic              w_held_r, w_held_nxt;   // write data captured
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              awready_nxt, wready_nxt;
    logic              bvalid_nxt;
    logic [1:0]        bresp_nxt;
    logic              arready_nxt, rvalid_nxt;
    logic [31:0]       rdata_nxt;
    logic [1:0]        rresp_nxt;

    logic        wr_fire;                      // both halves of a write held
    logic        wr_access;                    // write hits access register
    logic        set_clr, set_go;              // software set requests

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    // true when the offset names one of the three registers
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = 8'(a) & 8'hfc;
        return (w == VERSION_OFS) || (w == ACCESS_OFS) || (w == RETRY_OFS);
    endfunction : is_mapped

    // read-back value of a register; reserved bits are zero
    function automatic logic [31:0] reg_value(input logic [ADDR_W-1:0] a);
        logic [7:0]  w;
        logic [31:0] v;
        w = 8'(a) & 8'hfc;
        v = 32'h0000_0000;
        case (w)
            VERSION_OFS: begin
                v[PRESENT_BIT]   = present_r;
                v[23:16]         = VERSION_MAJOR;
                v[7:0]           = VERSION_MINOR;
            end
            ACCESS_OFS: begin
                v[ADDR_CLEAR_BIT]                   = clr_r;
                v[READ_GO_BIT]                      = go_r;
                v[READ_BYTE_LSB +: 8]               = rd.read_byte;
                v[POINTER_LSB +: 8]                 = rd.pointer;
            end
            RETRY_OFS: begin
                v[11:0] = retry_r;     // upper limits stay zero
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_value

    //--------------------------------------------------------------------------
    // byte reader
    //--------------------------------------------------------------------------
    assign rd.read_go    = go_r;
    assign rd.addr_clear = clr_r;

    rom_byte_reader i_rom_byte_reader (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .rd         (rd.reader),
        .present_i  (present_r),
        .rom_req_o  (rom_req_o),
        .rom_addr_o (rom_addr_o),
        .rom_ack_i  (rom_ack_i),
        .rom_data_i (rom_data_i)
    );

    //--------------------------------------------------------------------------
    // retry counters, one per transmit unit
    //--------------------------------------------------------------------------
    for (genvar u = 0; u < RETRY_UNITS; u++) begin : g_retry
        retry_limiter #(
            .CNT_W (RETRY_W)
        ) i_retry_limiter (
            .sys_clk_i   (sys_clk_i),
            .rst_i       (rst_i),
            .limit_i     (retry_r[u*RETRY_W +: RETRY_W]),
            .tx_done_i   (tx_done_i[u]),
            .ack_retry_i (ack_retry_i[u]),
            .resend_o    (resend_o[u]),
            .give_up_o   (give_up_o[u])
        );
    end

    //--------------------------------------------------------------------------
    // write channel
    //--------------------------------------------------------------------------
    assign wr_fire   = aw_held_r && w_held_r;
    assign wr_access = wr_fire && ((8'(aw_addr_r) & 8'hfc) == ACCESS_OFS);
    // both control bits sit in byte lane 3
    assign set_clr   = wr_access && w_strb_r[3] && w_data_r[ADDR_CLEAR_BIT];
    assign set_go    = wr_access && w_strb_r[3] && w_data_r[READ_GO_BIT];

    // address and data are taken in either order, answered once both held
    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = s_axi_bvalid_o;
        bresp_nxt   = s_axi_bresp_o;
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;                 // response taken
        end
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata_i;
            w_strb_nxt = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end
        // accept nothing new while a response is pending
        awready_nxt = !aw_held_nxt && !bvalid_nxt;
        wready_nxt  = !w_held_nxt && !bvalid_nxt;
    end

    // write channel registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_held_r       <= 1'b0;
            aw_addr_r       <= '0;
            w_held_r        <= 1'b0;
            w_data_r        <= 32'h0000_0000;
            w_strb_r        <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
        end else begin
            aw_held_r       <= aw_held_nxt;
            aw_addr_r       <= aw_addr_nxt;
            w_held_r        <= w_held_nxt;
            w_data_r        <= w_data_nxt;
            w_strb_r        <= w_strb_nxt;
            s_axi_awready_o <= awready_nxt;
            s_axi_wready_o  <= wready_nxt;
            s_axi_bvalid_o  <= bvalid_nxt;
            s_axi_bresp_o   <= bresp_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // read channel
    //--------------------------------------------------------------------------
    // one read in flight; data sampled at the address handshake
    always_comb begin
        rvalid_nxt = s_axi_rvalid_o;
        rdata_nxt  = s_axi_rdata_o;
        rresp_nxt  = s_axi_rresp_o;
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = reg_value(s_axi_araddr_i);
            rresp_nxt  = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    // read channel registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= arready_nxt;
            s_axi_rvalid_o  <= rvalid_nxt;
            s_axi_rdata_o   <= rdata_nxt;
            s_axi_rresp_o   <= rresp_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // control and limit registers
    //--------------------------------------------------------------------------
    // the software set wins over a completion landing in the same cycle,
    // so a back-to-back request is never lost
    always_comb begin
        present_nxt = present_r | eeprom_detect_i;
        clr_nxt     = (clr_r && !rd.clear_done) || set_clr;
        go_nxt      = (go_r && !rd.read_done) || set_go;
        retry_nxt   = retry_r;
        if (wr_fire && ((8'(aw_addr_r) & 8'hfc) == RETRY_OFS)) begin
            if (w_strb_r[0]) begin
                retry_nxt[7:0] = w_data_r[7:0];
            end
            if (w_strb_r[1]) begin
                retry_nxt[11:8] = w_data_r[11:8];
            end
        end
    end

    // control registers; the present flag clears only under reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            present_r <= 1'b0;
            clr_r     <= 1'b0;
            go_r      <= 1'b0;
            retry_r   <= RETRY_RESET;
        end else begin
            present_r <= present_nxt;
            clr_r     <= clr_nxt;
            go_r      <= go_nxt;
            retry_r   <= retry_nxt;
        end
    end
endmodule : id_rom_access_and_retry_regs
`default_nettype wire

// ---- id_rom_regs_checker.sv ----
// checker: eeprom port, read data and retry pulse properties
`timescale 1ns/1ps
`default_nettype none
module id_rom_regs_checker
    import id_rom_regs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic              s_axi_rvalid_o,
    input wire logic              rom_req_o,
    input wire logic [7:0]        rom_addr_o,
    input wire logic              rom_ack_i,
    input wire logic [2:0]        tx_done_i,
    input wire logic [2:0]        ack_retry_i,
    input wire logic [2:0]        resend_o,
    input wire logic [2:0]        give_up_o
);
    // address of the read in flight
    logic [ADDR_W-1:0] ra_r, ra_nxt;
    always_comb ra_nxt = (s_axi_arvalid_i && s_axi_arready_o) ? s_axi_araddr_i : ra_r;
    always_ff @(posedge sys_clk_i) ra_r <= rst_i ? '0 : ra_nxt;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // a byte request waiting, and answered
    sequence s_wait; rom_req_o && !rom_ack_i; endsequence
    sequence s_got; rom_req_o && rom_ack_i; endsequence
    a_req_hold: assert property (s_wait |=> rom_req_o && $stable(rom_addr_o))
        else $error("byte request not held");
    a_req_drop: assert property (s_got |=> !rom_req_o)
        else $error("byte request kept");
    a_read_next: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_rsv_access: assert property (s_axi_rvalid_o && ra_r == ACCESS_OFS |-> (s_axi_rdata_o & 32'h7d00_ff00) == 0)
        else $error("access reserved bits set");
    a_rsv_retry: assert property (s_axi_rvalid_o && ra_r == RETRY_OFS |-> s_axi_rdata_o[31:12] == 20'h0)
        else $error("retry upper bits set");
    a_ver_fixed: assert property (s_axi_rvalid_o && ra_r == VERSION_OFS |-> s_axi_rdata_o[23:0] == 24'h01_0010)
        else $error("version fields wrong");
    a_retry_cause: assert property ((resend_o | give_up_o) == $past(tx_done_i & ack_retry_i))
        else $error("retry pulse without bad ack");
    a_one_kind: assert property ((resend_o & give_up_o) == 3'b000)
        else $error("resend and give up together");
endmodule : id_rom_regs_checker
bind id_rom_access_and_retry_regs id_rom_regs_checker #(.ADDR_W(ADDR_W)) i_id_rom_regs_checker (.*);
`default_nettype wire

// ---- eeprom_model.sv ----
// model: serial eeprom, answering after a random wait
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
    input  wire logic       clk_i,
    input  wire logic       req_i,
    input  wire logic [7:0] addr_i,
    output logic            ack_o,
    output logic [7:0]      data_o
);
    int unsigned wt = 2;  // cycles to next answer
    // fixed pattern; word 28h holds a pointer above 3ah
    function automatic logic [7:0] mem(input logic [7:0] a);
        return (a == 8'h28) ? 8'h4c : (a ^ 8'ha5);
    endfunction : mem
    // data lines toggle outside answers so a stale byte is never caught by luck
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        data_o <= ~data_o;
        if (req_i && !ack_o) begin
            if (wt == 0) begin
                {ack_o, data_o} <= {1'b1, mem(addr_i)};
                wt <= $urandom_range(3, 0);
            end else wt <= wt - 1;
        end
    end
endmodule : eeprom_model
`default_nettype wire

// ---- test_id_rom_access_and_retry_regs.sv ----
// testbench: register access, eeprom byte walk and retry pulses
`timescale 1ns/1ps
`default_nettype none
module test_id_rom_access_and_retry_regs;
    import id_rom_regs_pkg::*;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, eeprom_detect_i = 1'b0, rom_req_o, rom_ack_i;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic [3:0]  s_axi_wstrb_i = 4'hf, cnt [3];
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, rom_addr_o, rom_data_i, b = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, last_rd, w;
    logic [2:0]  tx_done_i = 3'h0, ack_retry_i = 3'h0, resend_o, give_up_o, rs, gu;
    logic [33:0] eq [$], mq [$], uq [$], m;
    int          n_fail = 0, check_count = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    id_rom_access_and_retry_regs #(.ADDR_W(8)) i_id_rom_access_and_retry_regs (.*);
    eeprom_model i_eeprom_model (.clk_i(sys_clk_i), .req_i(rom_req_o), .addr_i(rom_addr_o),
                                 .ack_o(rom_ack_i), .data_o(rom_data_i));
    // one counted compare
    task automatic check(input string n, input logic [33:0] s, e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check
    // one axi4-lite transfer; answer noted with a mask
    task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e, k);
        @(posedge sys_clk_i);
        eq.push_back(e);
        mq.push_back(k);
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, d};
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{wr}};
        {s_axi_arvalid_i, s_axi_rready_i} <= {2{!wr}};
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!(s_axi_bvalid_o || s_axi_rvalid_o));
        last_rd = s_axi_rdata_o;
        {s_axi_bready_i, s_axi_rready_i} <= 2'b00;
    endtask : bus
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // monitor: each answer takes the oldest note
    always @(posedge sys_clk_i) begin
        if ((s_axi_rvalid_o && s_axi_rready_i) || (s_axi_bvalid_o && s_axi_bready_i)) begin
            m = mq.pop_front();
            check("bus", (s_axi_rvalid_o ? {s_axi_rresp_o, s_axi_rdata_o} : {32'h0, s_axi_bresp_o}) & m, eq.pop_front() & m);
        end
        if (resend_o | give_up_o) check("retry", {28'h0, resend_o, give_up_o}, uq.pop_front());
    end
    initial begin
        void'($urandom(32'hca05f87d));
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        bus(0, VERSION_OFS, 0, 34'h0_0001_0010, '1);
        bus(0, ACCESS_OFS, 0, 34'h0, '1);
        bus(0, RETRY_OFS, 0, 34'h0, '1);
        bus(1, 8'h0c, '1, {32'h0, RESP_SLVERR}, '1);
        bus(0, 8'h0c, 0, {RESP_SLVERR, 32'h0}, '1);
        $display("reset values done");
        // detect pulse before any byte access; the flag must stay
        eeprom_detect_i <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
        eeprom_detect_i <= 1'b0;
        bus(0, VERSION_OFS, 0, 34'h0_0101_0010, '1);
        for (int j = 0; j < 4; j++) begin
            if (j % 2 == 0) begin
                bus(1, ACCESS_OFS, 32'h8000_0000, 34'h0, '1);
                do bus(0, ACCESS_OFS, 0, 0, 0); while (last_rd[ADDR_CLEAR_BIT] !== 1'b0);
                bus(0, ACCESS_OFS, 0, {10'h0, b, 16'h004c}, '1);
            end
            bus(1, ACCESS_OFS, 32'h0200_0000, 34'h0, '1);
            do bus(0, ACCESS_OFS, 0, 0, 0); while (last_rd[READ_GO_BIT] !== 1'b0);
            b = 8'ha5 ^ 8'(j % 2);
            bus(0, ACCESS_OFS, 0, {10'h0, b, 16'h004c}, '1);
        end
        $display("byte reads done");
        // random then zero limits; back-to-back bad acks, then a good one
        for (int p = 0; p < 2; p++) begin
            w = p ? 32'h0 : $urandom;
            bus(1, RETRY_OFS, w, 34'h0, '1);
            bus(0, RETRY_OFS, 0, {22'h0, w[11:0]}, '1);
            cnt = '{default: 4'h0};
            repeat (17) begin
                for (int k = 0; k < 3; k++)
                    {rs[k], gu[k], cnt[k]} = (cnt[k] < w[4*k +: 4]) ? {2'b10, cnt[k] + 4'h1} : {2'b01, 4'h0};
                uq.push_back({28'h0, rs, gu});
                @(posedge sys_clk_i);
                {tx_done_i, ack_retry_i} <= 6'h3f;
            end
            @(posedge sys_clk_i);
            ack_retry_i <= 3'h0;
            @(posedge sys_clk_i);
            tx_done_i <= 3'h0;
        end
        $display("retry units done");
        summarize();
    end
    // watchdog: the run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        summarize();
    end
endmodule : test_id_rom_access_and_retry_regs
`default_nettype wire
